/* hw/iic_ctrl.sv */
/*
 * Indicator controller: executes the indicator test, reset, io inhibit,
 * conditional jump and stand-by load instructions, keeps the error and
 * per-channel io flags, and takes the two automatic interrupts.
 * Assumes instructions, the indexed address and the operand word come
 * from the processor on clk, and synchronizer events are on clk too.
 */
`timescale 1ns/10ps
`include "iic_params.svh"
module iic_ctrl
	import iic_pkg::*;
#(
	parameter int          NCH       = 13,
	parameter int          W         = 7,
	parameter logic [14:0] PE_VECTOR = 15'h0000
)
(
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   instr_valid,
	input  wire logic [24:0]            instr_word,
	input  wire logic [14:0]            eff_addr,
	input  wire logic [24:0]            opnd_word,
	output      logic                   instr_ready,
	output      logic                   instr_done,
	input  wire logic                   addr_err_valid,
	input  wire logic [3:0]             addr_err_src,
	input  wire logic                   mod3_instr_err,
	input  wire logic                   mod3_opnd_err,
	input  wire logic                   adder_err,
	input  wire logic [NCH-1:0][W-1:0]  chan_set,
	input  wire logic [NCH-1:0]         chan_interlock_clr,
	output      logic [14:0]            control_counter,
	output      logic [14:0]            saved_cc,
	output      logic                   pe_int_taken,
	output      logic                   io_int_taken,
	output      logic                   io_inhibit,
	output      logic                   sb_wr,
	output      logic [3:0]             sb_addr,
	output      logic [24:0]            sb_data,
	input  wire logic [3:0]             reg_addr,
	input  wire logic [15:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output      logic [15:0]            reg_rdata
);
	iic_state_t          st_r;
	iic_kind_t           kind_r;
	iic_kind_t           dec_kind;
	logic [1:0]          cnt_r;
	logic [1:0]          dec_cyc;
	logic [5:0]          dec_op;
	logic [3:0]          dec_cls;
	logic [W-1:0]        mask_r;
	logic [3:0]          idx_r;
	logic [14:0]         addr_r;
	logic                jmp_r;
	logic [14:0]         cc_r;
	logic [14:0]         saved_r;
	logic                pe_mode_r;
	logic                io_mode_r;
	logic                holdoff_r;
	logic                inhibit_r;
	logic [3:0]          chsel_r;
	logic [3:0]          rd_idx;
	logic [15:0]         rdata_r;
	logic [3:0]          sb_addr_r;
	logic [24:0]         sb_data_r;
	logic [NCH-1:0][W-1:0] ch_flags;
	logic [W-1:0]        pe_flags;
	logic [W-1:0]        pe_set;
	logic [W-1:0]        sel_flags;
	logic                hit;
	logic                done;
	logic                accept;
	logic                take_pe;
	logic                take_io;
	logic                io_pend;
	logic                is_clear;

	assign dec_op  = instr_word[`IIC_OP_HI:`IIC_OP_LO];
	assign dec_cls = instr_word[`IIC_CLS_HI:`IIC_CLS_LO];

	// decode; test and clear with class codes 0 and 2, and load with class codes 0 to 2, fall through as no-effect instructions
	always_comb
	begin
		dec_kind = other_op;
		dec_cyc  = `IIC_CYC_STD;
		case (dec_op)
			`IIC_OPC_TEST:
			begin
				if (dec_cls == `IIC_CLS_PE)
					dec_kind = test_processor_error_op;
				else if (dec_cls >= `IIC_FIRST_CH)
					dec_kind = test_channel_flags_op;
			end
			`IIC_OPC_CLEAR:
			begin
				if (dec_cls == `IIC_CLS_PE)
					dec_kind = clear_processor_error_op;
				else if (dec_cls >= `IIC_FIRST_CH)
					dec_kind = clear_channel_flags_op;
			end
			`IIC_OPC_BLOCK:   dec_kind = block_io_interrupt_op;
			`IIC_OPC_UNBLOCK: dec_kind = unblock_io_interrupt_op;
			`IIC_OPC_JUMP:
			begin
				dec_kind = jump_if_io_blocked_op;
				if (inhibit_r)
					dec_cyc = `IIC_CYC_JUMP;
			end
			`IIC_OPC_LOAD:
			begin
				if (dec_cls >= `IIC_FIRST_CH)
				begin
					dec_kind = load_standby_op;
					dec_cyc  = `IIC_CYC_LOAD;
				end
			end
			default: dec_kind = other_op;
		endcase
	end

	// error indicator events; address error keeps its source as a value
	assign pe_set = {adder_err, mod3_opnd_err, mod3_instr_err,
		addr_err_valid ? addr_err_src : 4'h0};

	assign done     = (st_r == IIC_EXEC) && (cnt_r == 2'h0);
	assign is_clear = (kind_r == clear_processor_error_op) ||
		(kind_r == clear_channel_flags_op);

	always_comb
	begin
		io_pend = 1'b0;
		for (int i = 0; i < NCH; i++)
			io_pend = io_pend | (|(ch_flags[i] & `IIC_IO_IRQ_MASK));
	end

	// holdoff keeps both interrupts away until the next instruction ends
	assign take_pe = (st_r == IIC_IDLE) && (|pe_flags) && !pe_mode_r &&
		!holdoff_r;
	assign take_io = (st_r == IIC_IDLE) && io_pend && !inhibit_r &&
		!io_mode_r && !holdoff_r && !take_pe;
	assign accept  = instr_valid && instr_ready;

	assign instr_ready  = (st_r == IIC_IDLE) && !take_pe && !take_io;
	assign instr_done   = done;
	assign pe_int_taken = take_pe;
	assign io_int_taken = take_io;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_r  <= IIC_IDLE;
			cnt_r <= 2'h0;
		end
		else if (accept)
		begin
			st_r  <= IIC_EXEC;
			cnt_r <= dec_cyc - 2'h1;
		end
		else if (done)
			st_r  <= IIC_IDLE;
		else if (st_r == IIC_EXEC)
			cnt_r <= cnt_r - 2'h1;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			kind_r <= other_op;
			mask_r <= `IIC_NO_FLAGS;
			idx_r  <= 4'h0;
			addr_r <= 15'h0000;
			jmp_r  <= 1'b0;
		end
		else if (accept)
		begin
			kind_r <= dec_kind;
			// mask bits 8 to 10 select nothing
			mask_r <= instr_word[`IIC_MASK_HI:`IIC_MASK_LO];
			idx_r  <= dec_cls - `IIC_FIRST_CH;
			addr_r <= eff_addr;
			jmp_r  <= inhibit_r;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sb_addr_r <= 4'h0;
			sb_data_r <= 25'h0000000;
		end
		else if (accept && dec_kind == load_standby_op)
		begin
			sb_addr_r <= dec_cls;
			sb_data_r <= opnd_word;
		end
	end

	assign sb_wr   = done && (kind_r == load_standby_op);
	assign sb_addr = sb_addr_r;
	assign sb_data = sb_data_r;

	assign sel_flags = (kind_r == test_processor_error_op) ? pe_flags :
		((kind_r == test_channel_flags_op) ? ch_flags[idx_r] :
		`IIC_NO_FLAGS);
	assign hit = |(sel_flags & mask_r);

	always_ff @(posedge clk)
	begin
		if (!resetn)
			cc_r <= 15'h0000;
		else if (reg_wr && reg_addr == `IIC_REG_CC)
			cc_r <= reg_wdata[14:0];
		else if (take_pe)
			cc_r <= PE_VECTOR;
		else if (take_io)
			cc_r <= `IIC_IO_VECTOR;
		else if (done)
		begin
			case (kind_r)
				test_processor_error_op, test_channel_flags_op:
					cc_r <= cc_r + (hit ? `IIC_CC_ONE : `IIC_CC_TWO);
				jump_if_io_blocked_op:
					cc_r <= jmp_r ? addr_r : cc_r + `IIC_CC_ONE;
				default:
					cc_r <= cc_r + `IIC_CC_ONE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			saved_r <= 15'h0000;
		else if (take_pe || take_io)
			saved_r <= cc_r;
	end

	assign control_counter = cc_r;
	assign saved_cc        = saved_r;

	always_ff @(posedge clk)
	begin
		if (!resetn)
			pe_mode_r <= 1'b0;
		else if (take_pe)
			pe_mode_r <= 1'b1;
		else if (done && kind_r == clear_processor_error_op)
			pe_mode_r <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			io_mode_r <= 1'b0;
		else if (take_io)
			io_mode_r <= 1'b1;
		else if (done && kind_r == clear_channel_flags_op)
			io_mode_r <= 1'b0;
	end

	// a clear arms the holdoff; the next completed instruction releases it
	always_ff @(posedge clk)
	begin
		if (!resetn)
			holdoff_r <= 1'b0;
		else if (done)
			holdoff_r <= is_clear;
	end

	// inhibit gates only the taking; flags keep updating meanwhile
	always_ff @(posedge clk)
	begin
		if (!resetn)
			inhibit_r <= 1'b0;
		else if (done && kind_r == block_io_interrupt_op)
			inhibit_r <= 1'b1;
		else if (done && kind_r == unblock_io_interrupt_op)
			inhibit_r <= 1'b0;
	end

	assign io_inhibit = inhibit_r;

	iic_flag_if #(.W(W)) pe_if ();
	assign pe_if.set = pe_set;
	// testing leaves the bank alone: only the clear kind drives clr
	assign pe_if.clr = (done && kind_r == clear_processor_error_op) ?
		mask_r : `IIC_NO_FLAGS;
	assign pe_flags  = pe_if.flags;

	iic_flag_bank #(.W(W), .DEF(`IIC_PE_DEFINED)) u_pe_bank
	(
		.clk    (clk),
		.resetn (resetn),
		.port   (pe_if.bank)
	);

	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		iic_flag_if #(.W(W)) fi ();
		assign fi.set = chan_set[g] |
			((sb_wr && idx_r == 4'(g)) ? `IIC_INTERLOCK
			: `IIC_NO_FLAGS);
		assign fi.clr =
			((done && kind_r == clear_channel_flags_op &&
			idx_r == 4'(g)) ? mask_r : `IIC_NO_FLAGS) |
			(chan_interlock_clr[g] ? `IIC_INTERLOCK
			: `IIC_NO_FLAGS);
		assign ch_flags[g] = fi.flags;

		iic_flag_bank #(.W(W), .DEF(`IIC_CH_DEFINED)) u_bank
		(
			.clk    (clk),
			.resetn (resetn),
			.port   (fi.bank)
		);
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			chsel_r <= `IIC_FIRST_CH;
		else if (reg_wr && reg_addr == `IIC_REG_CHSEL)
			chsel_r <= reg_wdata[3:0];
	end

	assign rd_idx = chsel_r - `IIC_FIRST_CH;

	always_ff @(posedge clk)
	begin
		if (!resetn)
			rdata_r <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`IIC_REG_STATUS:
					rdata_r <= {5'h00, inhibit_r, io_mode_r, pe_mode_r,
						holdoff_r, pe_flags};
				`IIC_REG_CC:    rdata_r <= {1'b0, cc_r};
				`IIC_REG_CHSEL: rdata_r <= {12'h000, chsel_r};
				`IIC_REG_CHFLAGS:
					rdata_r <= (chsel_r >= `IIC_FIRST_CH) ?
						{9'h000, ch_flags[rd_idx]} : 16'h0000;
				`IIC_REG_SAVED: rdata_r <= {1'b0, saved_r};
				default:        rdata_r <= 16'h0000;
			endcase
		end
	end

	assign reg_rdata = rdata_r;

	a_test_skip: assert property (
		@(posedge clk) disable iff (!resetn)
		(done && !hit && (kind_r == test_processor_error_op ||
		kind_r == test_channel_flags_op) && !reg_wr) |=>
			cc_r == $past(cc_r) + `IIC_CC_TWO)
		else $error("skip did not add two");

	a_test_next: assert property (
		@(posedge clk) disable iff (!resetn)
		(done && hit && kind_r == test_channel_flags_op && !reg_wr) |=>
			cc_r == $past(cc_r) + `IIC_CC_ONE)
		else $error("hit did not add one");

	a_test_keep: assert property (
		@(posedge clk) disable iff (!resetn)
		(done && kind_r == test_processor_error_op) |=>
			(($past(pe_flags) & ~pe_flags) == `IIC_NO_FLAGS))
		else $error("test changed an indicator");

	a_pe_clear: assert property (
		@(posedge clk) disable iff (!resetn)
		(done && kind_r == clear_processor_error_op) |=>
			((pe_flags & $past(mask_r) & ~$past(pe_set)) == `IIC_NO_FLAGS))
		else $error("masked error flag not cleared");

	a_pe_mode: assert property (
		@(posedge clk) disable iff (!resetn)
		(done && kind_r == clear_processor_error_op) |=>
			(!pe_mode_r && holdoff_r && !take_io && !take_pe))
		else $error("error clear left mode or interrupts open");

	a_io_mode: assert property (
		@(posedge clk) disable iff (!resetn)
		(done && kind_r == clear_channel_flags_op) |=> !io_mode_r && holdoff_r)
		else $error("io clear left mode flag");

	a_no_take: assert property (
		@(posedge clk) disable iff (!resetn)
		(inhibit_r && io_pend && (st_r == IIC_IDLE) && !take_pe &&
		!(reg_wr && reg_addr == `IIC_REG_CC)) |=>
			((cc_r == $past(cc_r)) && (saved_r == $past(saved_r))))
		else $error("io interrupt taken while inhibited");

	a_jump_taken: assert property (
		@(posedge clk) disable iff (!resetn)
		(accept && dec_kind == jump_if_io_blocked_op && inhibit_r) |=>
			done ##1 (cc_r == $past(addr_r)))
		else $error("inhibited jump not one cycle to target");

	a_load_time: assert property (
		@(posedge clk) disable iff (!resetn)
		(accept && dec_kind == load_standby_op) |->
			##1 !sb_wr ##1 !sb_wr ##1 sb_wr)
		else $error("stand-by load not three cycles");

	a_block_set: assert property (
		@(posedge clk) disable iff (!resetn)
		(done && kind_r == block_io_interrupt_op) |=> io_inhibit)
		else $error("block did not set inhibit");

endmodule : iic_ctrl

/* hw/iic_params.svh */
/*
 * Constants of the indicator controller: instruction fields, operation
 * and class codes, indicator layouts, cycle counts and register offsets.
 * Assumes it is included by bare name wherever these names are used.
 */
// Overview of operation
// - fields: indirect 25, index 24-21, opcode 20-15, class 14-11, mask 10-1
// - class 0001 error test examines every marked mask bit at once
// - any tested indicator set advances counter by one, otherwise by two
// - test instructions never change any indicator
// - address errors coded 1 fetch, 2 operand, 3-15 channel synchronizer
// - more error flags: 16 instruction check, 32 operand check, 64 adder
// - opcode 65 class 0001 clears masked error flags in two cycles
// - several mask bits clear all selected indicators together
// - clearing an already clear or undefined indicator raises no error
// - error clear drops its mode flag, holds off interrupts one instruction
// - opcode 64 with channel tests its masked flags, skip as usual
// - channel numbers 3 to 15 are recognised
// - channel flags at mask bits 3 to 7; bits 8 to 10 stay zero
// - stand-by interlock indicator sits at mask bit 1
// - opcode 65 with channel clears that channel's masked flags
// - channel flag clear drops io mode flag and holds off interrupts
// - opcode 62 sets the io interrupt inhibit flag
// - while inhibited, no counter save and no transfer to 0020
// - channel flags keep setting and clearing while inhibited
// - opcode 61 clears inhibit; pending io interrupt is then taken
// - opcode 60 jumps in one cycle if inhibited, else plus one in two
// - opcode 70 writes stand-by word, sets interlock, three cycles
`ifndef IIC_PARAMS_SVH
`define IIC_PARAMS_SVH

`define IIC_WORD_W     25
`define IIC_OP_HI      19
`define IIC_OP_LO      14
`define IIC_CLS_HI     13
`define IIC_CLS_LO     10
`define IIC_MASK_HI    6
`define IIC_MASK_LO    0

`define IIC_OPC_TEST    6'h34
`define IIC_OPC_CLEAR   6'h35
`define IIC_OPC_BLOCK   6'h32
`define IIC_OPC_UNBLOCK 6'h31
`define IIC_OPC_JUMP    6'h30
`define IIC_OPC_LOAD    6'h38

`define IIC_CLS_PE      4'h1
`define IIC_FIRST_CH    4'h3

`define IIC_CH_DEFINED  7'h7d
`define IIC_PE_DEFINED  7'h7f
`define IIC_INTERLOCK   7'h01
`define IIC_IO_IRQ_MASK 7'h7c
`define IIC_NO_FLAGS    7'h00

`define IIC_CYC_STD     2'h2
`define IIC_CYC_JUMP    2'h1
`define IIC_CYC_LOAD    2'h3

`define IIC_IO_VECTOR   15'h0010
`define IIC_CC_ONE      15'h0001
`define IIC_CC_TWO      15'h0002

`define IIC_REG_STATUS  4'h0
`define IIC_REG_CC      4'h1
`define IIC_REG_CHSEL   4'h2
`define IIC_REG_CHFLAGS 4'h3
`define IIC_REG_SAVED   4'h4

`endif

/* hw/iic_pkg.sv */
/*
 * Types of the indicator controller: sequencer states and decoded
 * instruction kinds. Assumes iic_params.svh is on the include path.
 */
package iic_pkg;

	typedef enum logic [0:0]
	{
		IIC_IDLE = 1'b0,
		IIC_EXEC = 1'b1
	} iic_state_t;

	typedef enum logic [3:0]
	{
		other_op                 = 4'h0,
		test_processor_error_op  = 4'h1,
		clear_processor_error_op = 4'h2,
		test_channel_flags_op    = 4'h3,
		clear_channel_flags_op   = 4'h4,
		block_io_interrupt_op    = 4'h5,
		unblock_io_interrupt_op  = 4'h6,
		jump_if_io_blocked_op    = 4'h7,
		load_standby_op          = 4'h8
	} iic_kind_t;

endpackage : iic_pkg

/* hw/iic_flag_if.sv */
/*
 * Carrier between the controller and one bank of indicator flags.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps
interface iic_flag_if #(parameter int W = 7);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] flags;

	modport bank (input set, input clr, output flags);
	modport ctrl (output set, output clr, input flags);
endinterface : iic_flag_if

/* hw/iic_flag_bank.sv */
/*
 * One bank of sticky indicator flags, set by hardware, cleared by mask.
 * Assumes set and clr come from logic on clk; undefined bits stay zero.
 */
`timescale 1ns/10ps
module iic_flag_bank
	import iic_pkg::*;
#(
	parameter int           W   = 7,
	parameter logic [W-1:0] DEF = '1
)
(
	input wire logic clk,
	input wire logic resetn,
	iic_flag_if.bank port
);
	logic [W-1:0] flags_r;

	// set beats clear so a same-cycle event is never lost
	always_ff @(posedge clk)
	begin
		if (!resetn)
			flags_r <= '0;
		else
			flags_r <= ((flags_r & ~port.clr) | port.set) & DEF;
	end

	assign port.flags = flags_r;

	a_set_wins: assert property (
		@(posedge clk) disable iff (!resetn)
		((port.set & DEF) != '0) |=>
			((flags_r & $past(port.set & DEF)) == $past(port.set & DEF)))
		else $error("flag set lost");

	a_undef_zero: assert property (
		@(posedge clk) disable iff (!resetn)
		(flags_r & ~DEF) == '0)
		else $error("undefined flag bit is set");

	a_clr_drops: assert property (
		@(posedge clk) disable iff (!resetn)
		((port.clr & ~port.set) != '0) |=>
			((flags_r & $past(port.clr & ~port.set)) == '0))
		else $error("cleared flag still set");

endmodule : iic_flag_bank

/* testbench/iic_sync_model.sv */
/*
 * Channel synchronizer stand-in: pulses channel flag sets and clears the
 * stand-by interlock once a waiting word has been started.
 * Assumes one clock shared with iic_ctrl; channel index 0 is channel 3.
 */
`timescale 1ns/10ps
module iic_sync_model
(
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             ev_go,
	input  wire logic [3:0]       ev_ch,
	input  wire logic [6:0]       ev_bits,
	input  wire logic             start_go,
	input  wire logic [3:0]       start_ch,
	input  wire logic             sb_wr,
	input  wire logic [3:0]       sb_addr,
	output      logic [12:0][6:0] chan_set,
	output      logic [12:0]      chan_interlock_clr
);
	logic [12:0] armed_r;

	// a start with no word waiting is simply lost, as on the real channel
	always @(posedge clk)
	begin
		chan_set           <= '0;
		chan_interlock_clr <= '0;
		if (!resetn)
			armed_r <= '0;
		else
		begin
			if (sb_wr)
				armed_r[sb_addr - 4'h3] <= 1'b1;
			if (ev_go)
				chan_set[ev_ch - 4'h3] <= ev_bits;
			if (start_go && armed_r[start_ch - 4'h3])
			begin
				chan_interlock_clr[start_ch - 4'h3] <= 1'b1;
				armed_r[start_ch - 4'h3]            <= 1'b0;
			end
		end
	end
endmodule : iic_sync_model

/* testbench/interrupt_indicator_control_tb_top.sv */
/*
 * Self-checking bench of the indicator controller with a synchronizer
 * model. Assumes iic_pkg, iic_ctrl and iic_sync_model are compiled first.
 */
`timescale 1ns/10ps
`include "iic_params.svh"
module interrupt_indicator_control_tb_top
	import iic_pkg::*;
;
	localparam logic [14:0] PEV = 15'h0200;
	logic             clk, resetn, instr_valid, instr_ready, instr_done;
	logic             addr_err_valid, mod3_instr_err, mod3_opnd_err;
	logic             adder_err, pe_int_taken, io_int_taken, io_inhibit;
	logic             sb_wr, reg_wr, reg_rd, ev_go, start_go, sbw;
	logic [24:0]      instr_word, opnd_word, sb_data, sbd;
	logic [14:0]      eff_addr, control_counter, saved_cc, ecc;
	logic [12:0][6:0] chan_set;
	logic [12:0]      chan_interlock_clr;
	logic [3:0]       addr_err_src, sb_addr, reg_addr, ev_ch, start_ch, sba;
	logic [15:0]      reg_wdata, reg_rdata;
	logic [6:0]       ev_bits;
	int               bad_count = 0;
	int               checks = 0;
	int               pe_cnt = 0;
	int               io_cnt = 0;

	iic_ctrl #(.PE_VECTOR(PEV)) uut (.clk, .resetn, .instr_valid,
		.instr_word, .eff_addr, .opnd_word, .instr_ready, .instr_done,
		.addr_err_valid, .addr_err_src, .mod3_instr_err, .mod3_opnd_err,
		.adder_err, .chan_set, .chan_interlock_clr, .control_counter,
		.saved_cc, .pe_int_taken, .io_int_taken, .io_inhibit, .sb_wr,
		.sb_addr, .sb_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);
	iic_sync_model sync (.clk, .resetn, .ev_go, .ev_ch, .ev_bits,
		.start_go, .start_ch, .sb_wr, .sb_addr, .chan_set,
		.chan_interlock_clr);

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		if (pe_int_taken === 1'b1) pe_cnt++;
		if (io_int_taken === 1'b1) io_cnt++;
	end

	task tally_and_finish;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	task chk(input logic [24:0] e, input logic [24:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	task reg_op(input logic w, input logic [3:0] a, input logic [15:0] d,
		input logic [15:0] e);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= w;
		reg_rd    <= !w;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		if (!w) chk({9'h0, e}, {9'h0, reg_rdata});
	endtask : reg_op

	task chf(input logic [3:0] ch, input logic [6:0] e);
		reg_op(1'b1, `IIC_REG_CHSEL, {12'h0, ch}, 16'h0);
		reg_op(1'b0, `IIC_REG_CHFLAGS, 16'h0, {9'h0, e});
	endtask : chf

	task exec(input logic [5:0] op, input logic [3:0] cl,
		input logic [9:0] mk, input logic [14:0] ea, input int cyc,
		input logic [14:0] nxt);
		int n;
		n = 0;
		@(posedge clk);
		instr_word  <= {5'h00, op, cl, mk};
		eff_addr    <= ea;
		instr_valid <= 1'b1;
		@(negedge clk);
		while (instr_ready !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		instr_valid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (instr_done !== 1'b1 && n < 10);
		sbw = sb_wr;
		sba = sb_addr;
		sbd = sb_data;
		@(posedge clk);
		#1;
		chk(25'(cyc), 25'(n));
		chk({10'h0, nxt}, {10'h0, control_counter});
		ecc = nxt;
	endtask : exec

	// the pulse may already be gone when called, so counters are compared
	task take_int(input logic io, input int cnt, input logic [14:0] vec);
		int n;
		n = 0;
		while ((io ? io_cnt : pe_cnt) < cnt && n < 10)
		begin
			@(posedge clk);
			n++;
		end
		#1;
		chk(25'(cnt), 25'(io ? io_cnt : pe_cnt));
		chk({10'h0, ecc}, {10'h0, saved_cc});
		chk({10'h0, vec}, {10'h0, control_counter});
		ecc = vec;
	endtask : take_int

	task raise(input logic [3:0] ch, input logic [6:0] b);
		@(posedge clk);
		ev_ch   <= ch;
		ev_bits <= b;
		ev_go   <= 1'b1;
		@(posedge clk);
		ev_go <= 1'b0;
	endtask : raise

	task sc_reset;
		reg_op(1'b0, `IIC_REG_STATUS, 16'h0, 16'h0000);
		reg_op(1'b1, 4'h9, 16'hffff, 16'h0);
		reg_op(1'b0, 4'h9, 16'h0, 16'h0000);
		reg_op(1'b1, `IIC_REG_CC, 16'h0100, 16'h0);
		ecc = 15'h0100;
		chk({10'h0, ecc}, {10'h0, control_counter});
		exec(`IIC_OPC_TEST, 4'h2, 10'h001, 0, 2, ecc + 1);
		exec(`IIC_OPC_LOAD, 4'h1, 10'h0, 0, 2, ecc + 1);
		chk(25'h0, {24'h0, sbw});
	endtask : sc_reset

	task sc_perr;
		@(posedge clk);
		addr_err_valid <= 1'b1;
		addr_err_src   <= 4'h5;
		mod3_instr_err <= 1'b1;
		mod3_opnd_err  <= 1'b1;
		adder_err      <= 1'b1;
		@(posedge clk);
		addr_err_valid <= 1'b0;
		mod3_instr_err <= 1'b0;
		mod3_opnd_err  <= 1'b0;
		adder_err      <= 1'b0;
		take_int(1'b0, 1, PEV);
		reg_op(1'b0, `IIC_REG_STATUS, 16'h0, 16'h0175);
		exec(`IIC_OPC_TEST, `IIC_CLS_PE, 10'h002, 0, 2, ecc + 2);
		exec(`IIC_OPC_TEST, `IIC_CLS_PE, 10'h050, 0, 2, ecc + 1);
		reg_op(1'b0, `IIC_REG_STATUS, 16'h0, 16'h0175);
		exec(`IIC_OPC_CLEAR, `IIC_CLS_PE, 10'h070, 0, 2, ecc + 1);
		reg_op(1'b0, `IIC_REG_STATUS, 16'h0, 16'h0085);
		chk(25'h1, 25'(pe_cnt));
		exec(`IIC_OPC_TEST, `IIC_CLS_PE, 10'h004, 0, 2, ecc + 1);
		take_int(1'b0, 2, PEV);
		exec(`IIC_OPC_CLEAR, `IIC_CLS_PE, 10'h3ff, 0, 2, ecc + 1);
		reg_op(1'b0, `IIC_REG_STATUS, 16'h0, 16'h0080);
	endtask : sc_perr

	task sc_inhibit;
		exec(`IIC_OPC_BLOCK, 4'h0, 10'h0, 0, 2, ecc + 1);
		chk(25'h1, {24'h0, io_inhibit});
		exec(`IIC_OPC_JUMP, 4'h0, 10'h0, 15'h1234, 1, 15'h1234);
		raise(4'h3, 7'h7f);
		raise(4'h5, 7'h10);
		repeat (4) @(posedge clk);
		chf(4'h3, 7'h7d);
		chf(4'h5, 7'h10);
		exec(`IIC_OPC_TEST, 4'h5, 10'h010, 0, 2, ecc + 1);
		exec(`IIC_OPC_TEST, 4'h5, 10'h008, 0, 2, ecc + 2);
		exec(`IIC_OPC_CLEAR, 4'h3, 10'h07f, 0, 2, ecc + 1);
		chf(4'h3, 7'h00);
		chk(25'h0, 25'(io_cnt));
		exec(`IIC_OPC_UNBLOCK, 4'h0, 10'h0, 0, 2, ecc + 1);
		chk(25'h0, {24'h0, io_inhibit});
		take_int(1'b1, 1, `IIC_IO_VECTOR);
		reg_op(1'b0, `IIC_REG_STATUS, 16'h0, 16'h0200);
		exec(`IIC_OPC_JUMP, 4'h0, 10'h0, 15'h1234, 2, ecc + 1);
		exec(`IIC_OPC_CLEAR, 4'h5, 10'h010, 0, 2, ecc + 1);
		reg_op(1'b0, `IIC_REG_STATUS, 16'h0, 16'h0080);
		chf(4'h5, 7'h00);
	endtask : sc_inhibit

	task sc_load;
		@(posedge clk);
		opnd_word <= 25'h1abcdef;
		exec(`IIC_OPC_LOAD, 4'h4, 10'h0, 15'h0321, 3, ecc + 1);
		chk(25'h1, {24'h0, sbw});
		chk(25'h4, {21'h0, sba});
		chk(25'h1abcdef, sbd);
		chf(4'h4, 7'h01);
		exec(`IIC_OPC_TEST, 4'h4, 10'h001, 0, 2, ecc + 1);
		@(posedge clk);
		start_ch <= 4'h4;
		start_go <= 1'b1;
		@(posedge clk);
		start_go <= 1'b0;
		repeat (3) @(posedge clk);
		exec(`IIC_OPC_TEST, 4'h4, 10'h001, 0, 2, ecc + 2);
		exec(`IIC_OPC_LOAD, 4'h4, 10'h0, 15'h0321, 3, ecc + 1);
		exec(`IIC_OPC_CLEAR, 4'h4, 10'h001, 0, 2, ecc + 1);
		chf(4'h4, 7'h00);
	endtask : sc_load

	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		{instr_valid, addr_err_valid, mod3_instr_err, mod3_opnd_err} = '0;
		{adder_err, reg_wr, reg_rd, ev_go, start_go} = '0;
		{instr_word, opnd_word, eff_addr, addr_err_src} = '0;
		{reg_addr, reg_wdata, ev_ch, ev_bits, start_ch} = '0;
		ecc = '0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		sc_reset;
		sc_perr;
		sc_inhibit;
		sc_load;
		tally_and_finish;
	end

	// whole run is well under two thousand cycles
	initial
	begin
		#200000;
		bad_count++;
		tally_and_finish;
	end
endmodule : interrupt_indicator_control_tb_top
